// *** design/readback_crc_pkg.sv ***
// Package: offsets, field positions, reset values and helpers of the bank
package readback_crc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] OFF_FREEZE_CTRL = 8'h14;
  localparam logic [7:0] OFF_INPUT_EN = 8'h15;
  localparam logic [7:0] OFF_BATT_HIGH = 8'h16;
  localparam logic [7:0] OFF_BATT_LOW = 8'h17;
  localparam logic [7:0] OFF_BOOST_HIGH = 8'h18;
  localparam logic [7:0] OFF_BOOST_LOW = 8'h19;
  localparam logic [7:0] OFF_TEMPA_HIGH = 8'h1a;
  localparam logic [7:0] OFF_TEMPA_LOW = 8'h1b;
  localparam logic [7:0] OFF_TEMPB_HIGH = 8'h1c;
  localparam logic [7:0] OFF_TEMPB_LOW = 8'h1d;
  localparam logic [7:0] OFF_CHECKSUM = 8'h20;
  localparam logic [7:0] OFF_CHECKSUM_CLR = 8'h21;
  localparam logic [7:0] OFF_BOOT_SEL = 8'h22;

  // Field positions
  localparam int BIT_FREEZE = 3;
  localparam int BIT_BATT_EN = 2;
  localparam int BIT_BOOST_EN = 1;
  localparam int BIT_TEMP_EN = 0;
  localparam int BIT_CHECKSUM_CLR = 0;
  localparam int BOOT_MSB = 3;
  localparam int LOW_PAIR_LSB = 6;

  // Values after reset
  localparam logic [2:0] RST_INPUT_EN = 3'h4;
  localparam logic RST_FREEZE = 1'b0;
  localparam logic [3:0] RST_BOOT_SEL = 4'h1;
  localparam logic [7:0] RST_CHECKSUM = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // Checksum polynomial x^8+x^2+x+1, low terms only
  localparam logic [7:0] CRC_POLY = 8'h07;

  // Converter channel codes
  localparam logic [1:0] CH_BATT = 2'h0;
  localparam logic [1:0] CH_BOOST = 2'h1;
  localparam logic [1:0] CH_TEMPA = 2'h2;
  localparam logic [1:0] CH_TEMPB = 2'h3;

  // Boot mode codes
  localparam logic [3:0] BOOT_PLAYBACK = 4'h1;
  localparam logic [3:0] BOOT_PLAY_SENSE = 4'h2;
  localparam logic [3:0] BOOT_PROTECT = 4'h3;
  localparam logic [3:0] BOOT_PROTECT_VOICE = 4'h4;

  // Upper eight bits of a 10-bit result
  function automatic logic [7:0] result_high(input logic [9:0] r);
    result_high = r[9:2];
  endfunction

  // Two low result bits placed in bits 7-6, rest zero
  function automatic logic [7:0] result_low(input logic [9:0] r);
    result_low = {r[1:0], 6'h00};
  endfunction

endpackage

// *** design/checksum_step.sv ***
// One-byte step of the running transaction checksum
`timescale 1ns/1ps
module checksum_step (
  input wire logic [7:0] crc_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] crc_o
);
  import readback_crc_pkg::*;

  // Bitwise shift register, most significant bit first
  always_comb begin
    logic [7:0] c;
    c = crc_i ^ byte_i;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc_o = c;
  end
endmodule

// *** design/sar_readback_crc_regs.sv ***
// Converter readback, input enable, checksum and boot select register bank
`timescale 1ns/1ps
module sar_readback_crc_regs (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Register port from the control bus decoder
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Every byte carried by the control bus
  input wire logic [7:0] bus_byte_i,
  input wire logic bus_byte_valid_i,
  // Finished conversions from the converter
  input wire logic [9:0] conv_result_i,
  input wire logic [1:0] conv_channel_i,
  input wire logic conv_valid_i,
  // Controls toward the converter and processor
  output logic battery_meas_enable_o,
  output logic boost_meas_enable_o,
  output logic temp_meas_enable_o,
  output logic readback_freeze_o,
  output logic [3:0] boot_mode_o,
  output logic [3:0] boot_onehot_o,
  output logic boot_reserved_o
);
  import readback_crc_pkg::*;

  typedef struct packed {
    logic [2:0] input_en;
    logic freeze;
    logic [3:0] boot;
    logic [3:0] boot_onehot;
    logic boot_reserved;
    logic [7:0] checksum;
    logic checksum_clr;
    logic [3:0][9:0] result;
    logic [7:0] rdata;
    logic rvalid;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [7:0] crc_base;
  logic [7:0] crc_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded boot mode; reserved codes raise a flag and select nothing
  function automatic logic [4:0] boot_decode(input logic [3:0] m);
    case (m)
      BOOT_PLAYBACK: boot_decode = 5'h01;
      BOOT_PLAY_SENSE: boot_decode = 5'h02;
      BOOT_PROTECT: boot_decode = 5'h04;
      BOOT_PROTECT_VOICE: boot_decode = 5'h08;
      default: boot_decode = 5'h10;
    endcase
  endfunction

  // Read multiplexer; unmapped offsets read as zero
  function automatic logic [7:0] reg_read(input state_s s,
                                          input logic [7:0] a);
    case (a)
      OFF_FREEZE_CTRL: reg_read = {4'h0, s.freeze, 3'h0};
      OFF_INPUT_EN: reg_read = {5'h00, s.input_en};
      OFF_BATT_HIGH: reg_read = result_high(s.result[CH_BATT]);
      OFF_BATT_LOW: reg_read = result_low(s.result[CH_BATT]);
      OFF_BOOST_HIGH: reg_read = result_high(s.result[CH_BOOST]);
      OFF_BOOST_LOW: reg_read = result_low(s.result[CH_BOOST]);
      OFF_TEMPA_HIGH: reg_read = result_high(s.result[CH_TEMPA]);
      OFF_TEMPA_LOW: reg_read = result_low(s.result[CH_TEMPA]);
      OFF_TEMPB_HIGH: reg_read = result_high(s.result[CH_TEMPB]);
      OFF_TEMPB_LOW: reg_read = result_low(s.result[CH_TEMPB]);
      OFF_CHECKSUM: reg_read = s.checksum;
      OFF_CHECKSUM_CLR: reg_read = {7'h00, s.checksum_clr};
      OFF_BOOT_SEL: reg_read = {4'h0, s.boot};
      default: reg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // A clear restarts from zero, so a byte in the same cycle is not lost
  assign crc_base = st_q.checksum_clr ? RST_CHECKSUM : st_q.checksum;

  checksum_step u_step (
    .crc_i(crc_base),
    .byte_i(bus_byte_i),
    .crc_o(crc_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole bank
  always_comb begin
    logic [4:0] dec;
    dec = 5'h00;
    st_d = st_q;
    // Clear bit lives one cycle, then normal checksum operation resumes
    st_d.checksum_clr = 1'b0;
    if (st_q.checksum_clr) begin
      st_d.checksum = RST_CHECKSUM;
    end
    if (bus_byte_valid_i) begin
      st_d.checksum = crc_next;
    end
    // Results land only when enabled and not frozen by the host
    if (conv_valid_i && !st_q.freeze) begin
      case (conv_channel_i)
        CH_BATT: begin
          if (st_q.input_en[BIT_BATT_EN]) begin
            st_d.result[CH_BATT] = conv_result_i;
          end
        end
        CH_BOOST: begin
          if (st_q.input_en[BIT_BOOST_EN]) begin
            st_d.result[CH_BOOST] = conv_result_i;
          end
        end
        default: begin
          if (st_q.input_en[BIT_TEMP_EN]) begin
            st_d.result[conv_channel_i] = conv_result_i;
          end
        end
      endcase
    end
    // Writes: read-only and unmapped offsets are ignored
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_FREEZE_CTRL: st_d.freeze = reg_wdata_i[BIT_FREEZE];
        OFF_INPUT_EN: begin
          st_d.input_en[BIT_BATT_EN] = reg_wdata_i[BIT_BATT_EN];
          st_d.input_en[BIT_BOOST_EN] = reg_wdata_i[BIT_BOOST_EN];
          st_d.input_en[BIT_TEMP_EN] = reg_wdata_i[BIT_TEMP_EN];
        end
        OFF_CHECKSUM_CLR: begin
          st_d.checksum_clr = reg_wdata_i[BIT_CHECKSUM_CLR];
        end
        OFF_BOOT_SEL: st_d.boot = reg_wdata_i[BOOT_MSB:0];
        default: ;
      endcase
    end
    dec = boot_decode(st_d.boot);
    st_d.boot_onehot = dec[3:0];
    st_d.boot_reserved = dec[4];
    // Read data sampled before this cycle's write takes effect
    st_d.rvalid = reg_rd_i;
    st_d.rdata = reg_rd_i ? reg_read(st_q, reg_addr_i) : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q.input_en <= RST_INPUT_EN;
      st_q.freeze <= RST_FREEZE;
      st_q.boot <= RST_BOOT_SEL;
      st_q.boot_onehot <= 4'h1;
      st_q.boot_reserved <= 1'b0;
      st_q.checksum <= RST_CHECKSUM;
      st_q.checksum_clr <= 1'b0;
      st_q.result <= {4{RST_RESULT}};
      st_q.rdata <= 8'h00;
      st_q.rvalid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign reg_rdata_o = st_q.rdata;
  assign reg_rvalid_o = st_q.rvalid;
  assign battery_meas_enable_o = st_q.input_en[BIT_BATT_EN];
  assign boost_meas_enable_o = st_q.input_en[BIT_BOOST_EN];
  assign temp_meas_enable_o = st_q.input_en[BIT_TEMP_EN];
  assign readback_freeze_o = st_q.freeze;
  assign boot_mode_o = st_q.boot;
  assign boot_onehot_o = st_q.boot_onehot;
  assign boot_reserved_o = st_q.boot_reserved;
endmodule

// *** test/sar_regs_sva.sv ***
// Port-level assertions for the readback and checksum bank
`timescale 1ns/1ps
module sar_regs_sva (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [9:0] conv_result_i,
  input wire logic [1:0] conv_channel_i,
  input wire logic conv_valid_i,
  input wire logic battery_meas_enable_o,
  input wire logic boost_meas_enable_o,
  input wire logic temp_meas_enable_o,
  input wire logic readback_freeze_o,
  input wire logic [3:0] boot_mode_o,
  input wire logic boot_reserved_o
);
  import readback_crc_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic en_wr;
  // Write strobe aimed at the input enable register
  assign en_wr = reg_wr_i && reg_addr_i == OFF_INPUT_EN;
  a_batt_en_wr: assert property (
    en_wr |=> battery_meas_enable_o == $past(reg_wdata_i[2]))
    else $error("battery enable not taken from write");
  a_boost_en_wr: assert property (
    en_wr |=> boost_meas_enable_o == $past(reg_wdata_i[1]))
    else $error("boost enable not taken from write");
  a_temp_en_wr: assert property (
    en_wr |=> temp_meas_enable_o == $past(reg_wdata_i[0]))
    else $error("temperature enable not taken from write");
  a_batt_high_read: assert property (
    conv_valid_i && conv_channel_i == CH_BATT && battery_meas_enable_o
    && !readback_freeze_o ##2 reg_rd_i && reg_addr_i == OFF_BATT_HIGH
    |=> reg_rdata_o == $past(conv_result_i[9:2], 3))
    else $error("battery high byte differs from result");
  a_low_reserved: assert property (
    reg_rd_i && reg_addr_i inside {8'h17, 8'h19, 8'h1b, 8'h1d}
    |=> reg_rdata_o[5:0] == 6'h00)
    else $error("reserved low bits not zero");
  a_clear_self: assert property (
    reg_wr_i && reg_addr_i == OFF_CHECKSUM_CLR && reg_wdata_i[0] ##2
    reg_rd_i && reg_addr_i == OFF_CHECKSUM_CLR |=> reg_rdata_o == 8'h00)
    else $error("checksum clear bit did not clear itself");
  a_boot_wr: assert property (
    reg_wr_i && reg_addr_i == OFF_BOOT_SEL
    |=> boot_mode_o == $past(reg_wdata_i[3:0]))
    else $error("boot mode not taken from write");
  a_boot_resv: assert property (
    boot_reserved_o == !(boot_mode_o inside {[4'h1:4'h4]}))
    else $error("boot reserved flag wrong");
endmodule

// *** test/host_model.sv ***
// Host stand-in driving the register port and the bus byte stream
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] byte_o,
  output logic byte_valid_o
);
  // Idle levels from time zero
  initial begin
    {addr_o, wdata_o, byte_o} = 24'h00_0000;
    {wr_o, rd_o, byte_valid_o} = 3'h0;
  end
  // Strobes rise and fall on falling edges; released lines are inverted
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
  endtask
  // Data missing its valid flag is returned as unknown
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    {addr_o, rd_o} = {a, 1'b1};
    @(negedge clk_i);
    {addr_o, rd_o} = {~a, 1'b0};
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk_i);
    {byte_o, byte_valid_o} = {b, 1'b1};
    @(negedge clk_i);
    {byte_o, byte_valid_o} = {~b, 1'b0};
  endtask
  // Clear first so stale traffic cannot spoil the block's sum
  task automatic download(input logic [7:0] q[$], output logic [7:0] c);
    wr_reg(8'h21, 8'h01);
    foreach (q[i]) send_byte(q[i]);
    rd_reg(8'h20, c);
  endtask
endmodule

// *** test/testbench.sv ***
// Top-level bench for the readback, checksum and boot select bank
`timescale 1ns/1ps
module testbench;
  import readback_crc_pkg::*;
  logic ref_clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, conv_valid_i;
  logic bus_byte_valid_i, battery_meas_enable_o, boost_meas_enable_o;
  logic temp_meas_enable_o, readback_freeze_o, boot_reserved_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, bus_byte_i, got, e;
  logic [9:0] conv_result_i;
  logic [1:0] conv_channel_i;
  logic [3:0] boot_mode_o, boot_onehot_o;
  logic [9:0] res[4] = '{10'h3ff, 10'h2c1, 10'h155, 10'h2aa};
  logic [3:0] modes[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
  logic [7:0] q[$] = '{8'h01, 8'ha5, 8'h3c};
  int mismatches = 0, checks_done = 0, cyc = 0;
  sar_readback_crc_regs u_dut (.*);
  host_model u_host (.clk_i(ref_clk_i), .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .byte_o(bus_byte_i),
    .byte_valid_o(bus_byte_valid_i));
  ////////////////////////////////////////////////////////////
  // Compare and count; case inequality, so an unknown value matches only the same unknown value
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h got %h", n, x, g);
    end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [7:0] x);
    u_host.rd_reg(a, got);
    chk(n, x, got);
  endtask
  task automatic conv(input logic [1:0] c, input logic [9:0] r);
    @(negedge ref_clk_i);
    {conv_channel_i, conv_result_i, conv_valid_i} = {c, r, 1'b1};
    @(negedge ref_clk_i);
    {conv_result_i, conv_valid_i} = {~r, 1'b0};
  endtask
  // Bitwise reference sum, kept apart from the design's own step
  function automatic logic [7:0] crc_ref(input logic [7:0] c,
                                         input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) begin
      c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Free-running clock and a hang guard far above the run length
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end
  // Test sequence
  initial begin
    {rstn_i, conv_valid_i, conv_result_i, conv_channel_i} = 14'h0;
    repeat (4) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    e = {battery_meas_enable_o, boost_meas_enable_o, temp_meas_enable_o,
      readback_freeze_o, boot_mode_o};
    chk("reset outputs", 8'h81, e);
    for (int a = 8'h14; a <= 8'h23; a++) begin
      e = (a == 8'h15) ? 8'h04 : (a == 8'h22) ? 8'h01 : 8'h00;
      rd_chk("reset map", 8'(a), e);
    end
    $display("test reset done");
    u_host.wr_reg(8'h15, 8'hfb);
    rd_chk("enables", 8'h15, 8'h03);
    conv(CH_BATT, 10'h155);
    rd_chk("dropped", 8'h16, 8'h00);
    u_host.wr_reg(8'h15, 8'h07);
    for (int c = 0; c < 4; c++) begin
      conv(2'(c), res[c]);
      e = res[c][9:2];
      rd_chk("high", 8'(8'h16 + 2 * c), e);
      e = {res[c][1:0], 6'h00};
      rd_chk("low", 8'(8'h17 + 2 * c), e);
    end
    u_host.wr_reg(8'h16, 8'h55);
    rd_chk("read only", 8'h16, 8'hff);
    u_host.wr_reg(8'h14, 8'h08);
    conv(CH_BOOST, 10'h000);
    rd_chk("frozen", 8'h18, 8'hb0);
    u_host.wr_reg(8'h14, 8'h00);
    conv(CH_BOOST, 10'h000);
    rd_chk("thawed", 8'h18, 8'h00);
    $display("test readback done");
    u_host.send_byte(8'h77);
    u_host.download(q, got);
    e = 8'h00;
    foreach (q[i]) e = crc_ref(e, q[i]);
    chk("checksum", e, got);
    u_host.wr_reg(8'h21, 8'hff);
    rd_chk("clear bit", 8'h21, 8'h00);
    rd_chk("cleared sum", 8'h20, 8'h00);
    $display("test checksum done");
    foreach (modes[i]) begin
      u_host.wr_reg(8'h22, {4'ha, modes[i]});
      rd_chk("boot", 8'h22, {4'h0, modes[i]});
      e = modes[i] inside {[1:4]} ? 8'h01 << (modes[i] - 1) : 8'h10;
      got = {3'h0, boot_reserved_o, boot_onehot_o};
      chk("boot decode", e, got);
    end
    $display("test boot done");
    summarize();
  end
endmodule
bind sar_readback_crc_regs sar_regs_sva u_sva (.*);
